// *** design/gpio_twowire_pkg.sv ***
package gpio_twowire_pkg;
    localparam int unsigned pin_count = 8;
    localparam logic [7:0] gpio_offset = 8'ha8;
    localparam logic [7:0] bus_status_offset = 8'hac;
    // Control and status register fields
    localparam int unsigned alt_lsb = 0;
    localparam int unsigned dir_lsb = 8;
    localparam int unsigned value_lsb = 16;
    // Management bus status register fields
    localparam int unsigned slave_addr_lsb = 1;
    localparam int unsigned master_addr_lsb = 9;
    localparam int unsigned addr_width = 7;
    localparam int unsigned load_done_bit = 24;
    localparam int unsigned nack_err_bit = 25;
    localparam int unsigned arb_err_bit = 26;
    localparam int unsigned arb_limit = 16;
    localparam logic [7:0] pin_reset = 8'h00;
    localparam logic [6:0] addr_reset = 7'h00;
endpackage

// *** design/gpio_and_twowire_status_regs.sv ***
`timescale 1ns/1ns
// Notes on behaviour
// - Alternate select bit routes pin to alternate function
// - General pin drives when direction bit one
// - Alternate mode ignores direction bit entirely
// - Pin value read returns live pin levels
// - Value write changes only general-purpose outputs
// - Slave bus address read-only, fixed at init
// - Master bus address read-only, fixed at init
// - Load-done set on boot load finish or error while boot load is enabled
// - Missing-ack flag set on nack, write-one clears
// - Lost arbitration retried automatically by master
// - Sixteen consecutive lost arbitrations abort, set flag, W1C
module gpio_and_twowire_status_regs
    import gpio_twowire_pkg::*;
#(
    parameter int unsigned pins = pin_count
) (
    // Clock, enable and resets
    input wire logic sys_clk,
    input wire logic clk_en,
    input wire logic reset_n,
    input wire logic fundamental_reset_n,
    // Register access
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // Pins
    input wire logic [pins-1:0] pin_in,
    output logic [pins-1:0] pin_out,
    output logic [pins-1:0] pin_oe_n,
    // Alternate function side
    input wire logic [pins-1:0] alt_out,
    input wire logic [pins-1:0] alt_oe_n,
    output logic [pins-1:0] alt_in,
    // Addresses straps, captured after reset release
    input wire logic [6:0] slave_addr_strap,
    input wire logic [6:0] master_addr_strap,
    // Boot load and master bus events
    input wire logic boot_load_enabled,
    input wire logic boot_load_finished,
    input wire logic boot_load_error,
    input wire logic master_nack,
    input wire logic arb_attempt_done,
    input wire logic arb_lost,
    output logic master_retry,
    output logic master_abort
);
    logic [pins-1:0] alt_function_select;
    logic [pins-1:0] pin_direction_select;
    logic [pins-1:0] pin_value;
    logic [6:0] slave_bus_address;
    logic [6:0] master_bus_address;
    logic addr_captured;
    logic boot_load_done;
    logic missing_ack_error;
    logic arbitration_loss_error;
    logic [4:0] lost_count;
    logic wr_gpio;
    logic wr_bus;
    logic [pins-1:0] gp_out_mask;
    logic abort_now;

    function automatic logic [pins-1:0] field(input logic [31:0] w, input int unsigned lsb);
        field = w[lsb +: pins];
    endfunction

    assign wr_gpio = clk_en && reg_write && (reg_addr == gpio_offset);
    assign wr_bus = clk_en && reg_write && (reg_addr == bus_status_offset);
    // Pins that are general-purpose and outputs
    assign gp_out_mask = ~alt_function_select & pin_direction_select;

    // Sticky control survives ordinary resets
    always_ff @(posedge sys_clk or negedge fundamental_reset_n) begin
        if (!fundamental_reset_n) begin
            alt_function_select <= pin_reset;
            pin_direction_select <= pin_reset;
        end else if (wr_gpio) begin
            alt_function_select <= field(reg_wdata, alt_lsb);
            pin_direction_select <= field(reg_wdata, dir_lsb);
        end
    end

    // Output latch only moves for bits that are general outputs now
    always_ff @(posedge sys_clk or negedge fundamental_reset_n) begin
        if (!fundamental_reset_n) begin
            pin_value <= pin_reset;
        end else if (wr_gpio) begin
            pin_value <= (field(reg_wdata, value_lsb) & gp_out_mask)
                | (pin_value & ~gp_out_mask);
        end
    end

    // Pin muxing
    always_comb begin
        for (int i = 0; i < pins; i++) begin
            if (alt_function_select[i]) begin
                pin_out[i] = alt_out[i];
                pin_oe_n[i] = alt_oe_n[i];
            end else begin
                pin_out[i] = pin_value[i];
                pin_oe_n[i] = ~pin_direction_select[i];
            end
        end
    end
    assign alt_in = pin_in;

    // Straps caught once after release; reset only reloads them
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_captured <= 1'b0;
            slave_bus_address <= addr_reset;
            master_bus_address <= addr_reset;
        end else if (clk_en && !addr_captured) begin
            addr_captured <= 1'b1;
            slave_bus_address <= slave_addr_strap;
            master_bus_address <= master_addr_strap;
        end
    end

    // Load-done is read-only; only reset clears it
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            boot_load_done <= 1'b0;
        end else if (clk_en && boot_load_enabled && (boot_load_finished || boot_load_error)) begin
            boot_load_done <= 1'b1;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            missing_ack_error <= 1'b0;
        end else if (clk_en && master_nack) begin
            missing_ack_error <= 1'b1;
        end else if (wr_bus && reg_wdata[nack_err_bit]) begin
            missing_ack_error <= 1'b0;
        end
    end

    // Consecutive loss counter; a won attempt restarts the run
    assign abort_now = clk_en && arb_attempt_done && arb_lost
        && (lost_count == 5'(arb_limit - 1));
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            lost_count <= 5'h00;
        end else if (clk_en && arb_attempt_done) begin
            if (!arb_lost || abort_now) begin
                lost_count <= 5'h00;
            end else begin
                lost_count <= lost_count + 5'h01;
            end
        end
    end
    assign master_retry = clk_en && arb_attempt_done && arb_lost && !abort_now;
    assign master_abort = abort_now;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            arbitration_loss_error <= 1'b0;
        end else if (abort_now) begin
            arbitration_loss_error <= 1'b1;
        end else if (wr_bus && reg_wdata[arb_err_bit]) begin
            arbitration_loss_error <= 1'b0;
        end
    end

    // Read data registered; reserved bits stay zero
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (clk_en && reg_read) begin
            reg_rdata <= 32'h0000_0000;
            if (reg_addr == gpio_offset) begin
                reg_rdata[alt_lsb +: pins] <= alt_function_select;
                reg_rdata[dir_lsb +: pins] <= pin_direction_select;
                reg_rdata[value_lsb +: pins] <= pin_in;
            end else if (reg_addr == bus_status_offset) begin
                reg_rdata[slave_addr_lsb +: addr_width] <= slave_bus_address;
                reg_rdata[master_addr_lsb +: addr_width] <= master_bus_address;
                reg_rdata[load_done_bit] <= boot_load_done;
                reg_rdata[nack_err_bit] <= missing_ack_error;
                reg_rdata[arb_err_bit] <= arbitration_loss_error;
            end
        end
    end
endmodule

// *** sim/regs_checker.sv ***
`timescale 1ns/1ns
module regs_checker
    import gpio_twowire_pkg::*;
#(
    parameter int unsigned pins = pin_count
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic clk_en,
    input wire logic reset_n,
    // Register access
    input wire logic reg_read,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_rdata,
    // Pins and master bus events
    input wire logic [pins-1:0] pin_in,
    input wire logic [pins-1:0] alt_in,
    input wire logic arb_attempt_done,
    input wire logic arb_lost,
    input wire logic master_retry,
    input wire logic master_abort
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    logic rd;
    logic loss;
    assign rd = reg_read && clk_en;
    assign loss = clk_en && arb_attempt_done && arb_lost;
    property p_alt_in; alt_in == pin_in; endproperty
    a_alt_in: assert property (p_alt_in) else $error("alt_in differs from pin");
    property p_gpio_read; rd && reg_addr == gpio_offset |=> reg_rdata[31:16] == {8'h00, $past(pin_in)}; endproperty
    a_gpio_read: assert property (p_gpio_read) else $error("bad pin read");
    property p_status_rsv; rd && reg_addr == bus_status_offset |=> reg_rdata[0] == 1'b0
        && reg_rdata[8] == 1'b0 && reg_rdata[23:16] == 8'h00 && reg_rdata[31:27] == 5'h00; endproperty
    a_status_rsv: assert property (p_status_rsv) else $error("status reserved set");
    property p_unmapped; rd && reg_addr != gpio_offset && reg_addr != bus_status_offset
        |=> reg_rdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    // Read data must not drift between reads, or software sees phantom changes
    property p_rdata_hold; !rd |=> $stable(reg_rdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_retry; loss |-> master_retry != master_abort; endproperty
    a_retry: assert property (p_retry) else $error("loss not retried or aborted");
    property p_cause; master_retry || master_abort |-> loss; endproperty
    a_cause: assert property (p_cause) else $error("retry or abort without loss");
    property p_abort_gap; master_abort |=> !master_abort [*8]; endproperty
    a_abort_gap: assert property (p_abort_gap) else $error("abort too soon");
    c_abort: cover property (master_abort);
    c_retry_run: cover property (master_retry ##1 master_retry);
    c_status_read: cover property (rd && reg_addr == bus_status_offset);
endmodule
bind gpio_and_twowire_status_regs regs_checker #(.pins(pins)) u_regs_checker (.*);

// *** sim/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
    import gpio_twowire_pkg::*;
    logic sys_clk = 0, clk_en = 1, reset_n = 0, fundamental_reset_n = 0, reg_write = 0;
    logic reg_read = 0, boot_load_enabled = 0, boot_load_finished = 0, boot_load_error = 0;
    logic master_nack = 0, arb_attempt_done = 0, arb_lost = 0, master_retry, master_abort;
    logic [7:0] reg_addr = 8'h00, pin_in = 8'h5c, alt_out = 8'hc3, alt_oe_n = 8'h96;
    logic [7:0] pin_out, pin_oe_n, alt_in;
    logic [6:0] slave_addr_strap = 7'h2d, master_addr_strap = 7'h51;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, q;
    logic [31:0] st = {16'h0, 7'h51, 1'b0, 7'h2d, 1'b0};
    int n_errors = 0, compares = 0;
    gpio_and_twowire_status_regs u_gpio_and_twowire_status_regs (.*);
    always #50 sys_clk = ~sys_clk;
    task automatic tick(int n = 1);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1;
        tick();
        reg_write = 0;
    endtask
    task automatic rd(logic [7:0] a);
        reg_addr = a;
        reg_read = 1;
        tick();
        reg_read = 0;
        q = reg_rdata;
    endtask
    task automatic t_status();
        slave_addr_strap = 7'h7f;
        wr(8'hb0, 32'hffff_ffff);
        rd(8'hb0);
        chk(q, 32'h0);
        wr(bus_status_offset, 32'hffff_ffff);
        rd(bus_status_offset);
        chk(q, st);
        master_nack = 1;
        tick();
        master_nack = 0;
        rd(bus_status_offset);
        chk(q, st | 32'h0200_0000);
        wr(bus_status_offset, 32'h0200_0000);
        rd(bus_status_offset);
        chk(q, st);
        $display("status test done");
    endtask
    task automatic t_gpio();
        wr(gpio_offset, 32'hff00_330f);
        wr(gpio_offset, 32'h00aa_330f);
        chk(pin_oe_n, (8'h0f & alt_oe_n) | (8'hf0 & ~8'h33));
        chk(pin_out & 8'h0f, alt_out & 8'h0f);
        chk(pin_out & 8'h30, 8'h20);
        // New outputs show the latch untouched by the earlier write
        wr(gpio_offset, 32'h00aa_ff0f);
        chk(pin_out & 8'hf0, 8'h20);
        pin_in = 8'ha7;
        rd(gpio_offset);
        chk(q, 32'h00a7_ff0f);
        reset_n = 0;
        tick();
        reset_n = 1;
        tick(2);
        rd(gpio_offset);
        chk(q[15:0], 16'hff0f);
        fundamental_reset_n = 0;
        tick();
        fundamental_reset_n = 1;
        rd(gpio_offset);
        chk(q[15:0], 16'h0000);
        $display("gpio test done");
    endtask
    // Nothing moves while the enable is low; a load error with boot load disabled is ignored
    task automatic t_freeze();
        clk_en = 0;
        master_nack = 1;
        wr(gpio_offset, 32'h0000_ffff);
        clk_en = 1;
        master_nack = 0;
        boot_load_error = 1;
        tick();
        boot_load_error = 0;
        rd(bus_status_offset);
        chk(q, {16'h0, 7'h51, 1'b0, 7'h7f, 1'b0});
        rd(gpio_offset);
        chk(q[15:0], 16'h0000);
        $display("freeze test done");
    endtask
    task automatic arb(logic lost, logic rt, logic ab);
        arb_attempt_done = 1;
        arb_lost = lost;
        #10 chk(master_retry, rt);
        chk(master_abort, ab);
        tick();
    endtask
    task automatic t_arb_boot();
        repeat (15) arb(1, 1, 0);
        arb(0, 0, 0);
        repeat (15) arb(1, 1, 0);
        arb(1, 0, 1);
        arb_attempt_done = 0;
        boot_load_enabled = 1;
        boot_load_finished = 1;
        tick();
        boot_load_finished = 0;
        rd(bus_status_offset);
        chk(q, 32'h0500_0000 | {16'h0, 7'h51, 1'b0, 7'h7f, 1'b0});
        wr(bus_status_offset, 32'hffff_ffff);
        rd(bus_status_offset);
        chk(q[26:24], 3'b001);
        $display("arbitration and boot test done");
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        tick(3);
        reset_n = 1;
        fundamental_reset_n = 1;
        tick(2);
        t_status();
        t_gpio();
        t_freeze();
        t_arb_boot();
        report_and_stop();
    end
endmodule
